// *** lsc_top.sv ***
// Behaviour
// - Regulator undervoltage pulls reset output low after fall delay, held low.
// - Reset output stays low 4 ms after regulator recovers.
// - Normal mode: low transmit input drives bus dominant, high leaves recessive.
// - Transmit low at Normal entry keeps driver off until high over 10 us.
// - Transmit low longer than 20 ms forces driver recessive.
// - After time-out, driver re-enabled only after 10 us high.
// - Stuck-low transmit still allows Sleep entry; mode uses actual transmit level.
// - Fail-Safe mode turns transmit pin into output showing fail-safe source.
// - Watchdog trigger counts only when low phase reaches minimum width.
// - Watchdog and oscillator reference off when disable input high; default on.
// - High-side output follows its control input; control defaults low.
// - High-side output forced off in Sleep mode.
// - After protective shutdown, high-side stays off until control goes low.
// - Limp-home output off at power-up and after Sleep wake-up.
// - Limp-home changes only in Normal and Fail-Safe; frozen in Silent.
// - Watchdog reset turns limp-home on; three good triggers turn it off.
// - Ignition wakes from Sleep or Silent on rising edge only.
// - Ignition input debounced about 100 us before wake-up accepted.
// - Local wake input low wakes device from Sleep or Silent.
// - Bus overtemperature turns driver off until cleared; receive output high.
// - Battery undervoltage inhibits bus transmission.
// - After power-up the device starts in Fail-Safe with regulator on.
// - Enable low with transmit high gives Silent; with transmit low, Sleep.
// - Missed open window or early trigger pulls reset low and turns limp-home on.
// - Silent mode forces receive output high.
`timescale 1ns/1ps
`default_nettype none
module lsc_top
  import lsc_pkg::*;
#(
  parameter logic [CW-1:0] RESET_HOLD = CW'(RESET_HOLD_CYC),
  parameter logic [CW-1:0] DOM_TO     = CW'(DOM_TO_CYC),
  parameter logic [CW-1:0] IGN_DB     = CW'(IGN_DB_CYC),
  parameter logic [CW-1:0] WD_LEAD    = CW'(WD_LEAD_CYC),
  parameter logic [CW-1:0] WD_CLOSED  = CW'(WD_CLOSED_CYC),
  parameter logic [CW-1:0] WD_OPEN    = CW'(WD_OPEN_CYC)
)(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       enable_in,
  input  wire logic       txd_in,
  output logic            txd_out,
  output logic            txd_oe_b,
  input  wire logic       watchdog_kick_n,
  input  wire logic       watchdog_disable_in,
  input  wire logic       highside_ctrl_in,
  input  wire logic       highside_fault_in,
  input  wire logic       ignition_wake_in,
  input  wire logic       local_wake_in,
  input  wire logic       supply_uv_in,
  input  wire logic       regulator_uv_in,
  input  wire logic       bus_overtemp_in,
  input  wire logic       bus_level_in,
  output logic            rxd_out,
  output logic            bus_dominant_out,
  output logic            uv_reset_b,
  output logic            limp_home_out,
  output logic            highside_switch_out,
  output logic            watchdog_osc_ref,
  output logic            regulator_on_out,
  output logic [1:0]      mode_out
);

  typedef struct packed {
    logic [SN-1:0] s1;
    logic [SN-1:0] s2;
    lsc_mode_t     mode;
    logic          armed;
    logic [CW-1:0] dom_cnt;
    logic [CW-1:0] hi_cnt;
    logic [CW-1:0] res_cnt;
    logic [CW-1:0] ign_cnt;
    logic          ign_stable;
    logic          hs_latch;
    logic          hs_out;
    logic          bus_drv;
    logic          rxd;
    logic          txd_o;
    logic          txd_oe_b;
    logic          nres_b;
    logic          lh;
    logic [1:0]    good_cnt;
    logic          fs_src;
    logic          osc_ref;
    logic          reg_on;
  } lsc_state_t;

  lsc_state_t q;
  lsc_state_t d;
  lsc_wd_if   wdi ();

  logic txd_lo;
  logic ign_rise;
  logic wake;
  logic wd_active;

  // Watchdog sees only synchronised levels
  assign wdi.en       = !q.s2[S_WDD] && (q.mode == LSC_NORMAL || q.mode == LSC_FAILSAFE);
  assign wdi.hold     = !q.nres_b;
  assign wdi.kick_lvl = q.s2[S_KCK];

  lsc_watchdog #(
    .LEAD_CYC   (WD_LEAD),
    .CLOSED_CYC (WD_CLOSED),
    .OPEN_CYC   (WD_OPEN)
  ) u_wd (
    .clk   (clk),
    .rst_b (rst_b),
    .wd    (wdi.wd)
  );

  always_comb
  begin
    d = q;
    // Two flops on every pin and analog flag
    d.s1 = {bus_level_in, bus_overtemp_in, regulator_uv_in, supply_uv_in, local_wake_in,
            ignition_wake_in, highside_fault_in, highside_ctrl_in, watchdog_disable_in,
            watchdog_kick_n, txd_in, enable_in};
    d.s2 = q.s1;
    txd_lo = !q.s2[S_TXD];
    wd_active = (q.mode == LSC_NORMAL) || (q.mode == LSC_FAILSAFE);

    // Ignition: debounce, then act on the rising edge only
    ign_rise = 1'h0;
    if (q.s2[S_IGN] != q.ign_stable)
    begin
      d.ign_cnt = lsc_inc(q.ign_cnt);
      if (q.ign_cnt >= IGN_DB)
      begin
        d.ign_stable = q.s2[S_IGN];
        d.ign_cnt = '0;
        ign_rise = q.s2[S_IGN];
      end
    end
    else
      d.ign_cnt = '0;
    wake = ign_rise || !q.s2[S_LWK];

    // Operating mode
    case (q.mode)
      LSC_FAILSAFE:
      begin
        if (q.s2[S_EN])
          d.mode = LSC_NORMAL;
      end
      LSC_NORMAL:
      begin
        // Actual transmit level decides, even after a time-out
        if (!q.s2[S_EN])
          d.mode = txd_lo ? LSC_SLEEP : LSC_SILENT;
      end
      LSC_SILENT:
      begin
        if (wake)
          d.mode = LSC_FAILSAFE;
        else if (q.s2[S_EN])
          d.mode = LSC_NORMAL;
      end
      LSC_SLEEP:
      begin
        if (wake)
          d.mode = LSC_FAILSAFE;
      end
      default:
        d.mode = LSC_FAILSAFE;
    endcase
    if (d.mode == LSC_FAILSAFE && q.mode != LSC_FAILSAFE)
      d.fs_src = FS_SRC_WAKE;

    // Transmit gating: dominant time-out and release
    if (txd_lo)
    begin
      d.hi_cnt = '0;
      d.dom_cnt = lsc_inc(q.dom_cnt);
      if (q.dom_cnt >= DOM_TO)
        d.armed = 1'h0;
    end
    else
    begin
      d.dom_cnt = '0;
      d.hi_cnt = lsc_inc(q.hi_cnt);
      if (q.hi_cnt >= CW'(TX_REL_CYC))
        d.armed = 1'h1;
    end
    // A stuck-low pin at entry must not drive the bus
    if (d.mode == LSC_NORMAL && q.mode != LSC_NORMAL)
      d.armed = !txd_lo;
    d.bus_drv = (q.mode == LSC_NORMAL) && (d.mode == LSC_NORMAL) && d.armed && txd_lo
                && !q.s2[S_OT]
                && !q.s2[S_BUV];
    d.rxd = (d.mode == LSC_NORMAL && !q.s2[S_OT]) ? q.s2[S_RX] : 1'h1;

    // Transmit pin reports the fail-safe source
    d.txd_oe_b = (d.mode != LSC_FAILSAFE);
    d.txd_o = (d.mode == LSC_FAILSAFE) ? d.fs_src : 1'h1;

    // High-side switch with latched protection
    if (q.s2[S_HSF])
      d.hs_latch = 1'h1;
    else if (!q.s2[S_HSC])
      d.hs_latch = 1'h0;
    d.hs_out = q.s2[S_HSC] && !q.s2[S_HSF] && !d.hs_latch
               && (d.mode != LSC_SLEEP);

    // Undervoltage reset output
    if (wdi.wd_rst)
    begin
      d.nres_b = 1'h0;
      d.res_cnt = '0;
    end
    else if (q.nres_b)
    begin
      if (q.s2[S_RUV])
      begin
        d.res_cnt = lsc_inc(q.res_cnt);
        if (q.res_cnt >= CW'(RES_FALL_CYC))
        begin
          d.nres_b = 1'h0;
          d.res_cnt = '0;
        end
      end
      else
        d.res_cnt = '0;
    end
    else if (q.s2[S_RUV])
      d.res_cnt = '0;
    else
    begin
      d.res_cnt = lsc_inc(q.res_cnt);
      if (q.res_cnt >= RESET_HOLD)
      begin
        d.nres_b = 1'h1;
        d.res_cnt = '0;
      end
    end

    // Limp-home: cleared on Sleep exit, otherwise only moves while the watchdog runs
    if (q.mode == LSC_SLEEP && d.mode != LSC_SLEEP)
    begin
      d.lh = 1'h0;
      d.good_cnt = '0;
    end
    else if (wd_active)
    begin
      if (wdi.wd_rst)
      begin
        d.lh = 1'h1;
        d.good_cnt = '0;
      end
      else if (wdi.trig_ok && q.lh)
      begin
        d.good_cnt = q.good_cnt + 2'h1;
        if (q.good_cnt == LH_GOOD_LAST)
        begin
          d.lh = 1'h0;
          d.good_cnt = '0;
        end
      end
    end

    d.osc_ref = !q.s2[S_WDD];
    d.reg_on = (d.mode != LSC_SLEEP);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      q <= '0;
      q.s1 <= SYNC_RST;
      q.s2 <= SYNC_RST;
      q.rxd <= 1'h1;
      q.txd_o <= FS_SRC_POWER;
      q.osc_ref <= 1'h1;
      q.reg_on <= 1'h1;
    end
    else
      q <= d;
  end

  assign txd_out             = q.txd_o;
  assign txd_oe_b            = q.txd_oe_b;
  assign rxd_out             = q.rxd;
  assign bus_dominant_out    = q.bus_drv;
  assign uv_reset_b          = q.nres_b;
  assign limp_home_out       = q.lh;
  assign highside_switch_out = q.hs_out;
  assign watchdog_osc_ref    = q.osc_ref;
  assign regulator_on_out    = q.reg_on;
  assign mode_out            = q.mode;

endmodule
`default_nettype wire

// *** lsc_pkg.sv ***
package lsc_pkg;

  // Internal oscillator, also the only clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_US     = 1000;
  localparam int US_PER_MS     = 1000;
  localparam int CW            = 24;
  localparam int TW            = 8;

  // Times in their own units
  localparam int RESET_HOLD_MS   = 4;
  localparam int RES_FALL_US     = 10;
  localparam int DOM_TIMEOUT_MS  = 20;
  localparam int TX_RELEASE_US   = 10;
  localparam int IGN_DEBOUNCE_US = 100;
  localparam int TRIG_MIN_NS     = 200;
  localparam int WD_LEAD_US      = 154800;
  localparam int WD_CLOSED_US    = 20640;
  localparam int WD_OPEN_US      = 21670;

  // Cycle counts; least times round up, longest times round down
  localparam int RESET_HOLD_CYC = (RESET_HOLD_MS * US_PER_MS * NS_PER_US + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int RES_FALL_CYC   = (RES_FALL_US * NS_PER_US) / CLK_PERIOD_NS;
  localparam int DOM_TO_CYC     = (DOM_TIMEOUT_MS * US_PER_MS * NS_PER_US) / CLK_PERIOD_NS;
  localparam int TX_REL_CYC     = (TX_RELEASE_US * NS_PER_US + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int IGN_DB_CYC     = (IGN_DEBOUNCE_US * NS_PER_US) / CLK_PERIOD_NS;
  localparam int TRIG_MIN_CYC   = (TRIG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WD_LEAD_CYC    = (WD_LEAD_US * NS_PER_US) / CLK_PERIOD_NS;
  localparam int WD_CLOSED_CYC  = (WD_CLOSED_US * NS_PER_US) / CLK_PERIOD_NS;
  localparam int WD_OPEN_CYC    = (WD_OPEN_US * NS_PER_US) / CLK_PERIOD_NS;

  // Synchroniser bit positions
  localparam int SN    = 12;
  localparam int S_EN  = 0;
  localparam int S_TXD = 1;
  localparam int S_KCK = 2;
  localparam int S_WDD = 3;
  localparam int S_HSC = 4;
  localparam int S_HSF = 5;
  localparam int S_IGN = 6;
  localparam int S_LWK = 7;
  localparam int S_BUV = 8;
  localparam int S_RUV = 9;
  localparam int S_OT  = 10;
  localparam int S_RX  = 11;

  // Pin defaults: pull-ups high, pull-downs low, regulator starts low
  localparam logic [SN-1:0] SYNC_RST = 12'hA86;
  localparam logic [1:0]    LH_GOOD_LAST = 2'h2;
  localparam logic          FS_SRC_POWER = 1'h0;
  localparam logic          FS_SRC_WAKE  = 1'h1;

  typedef enum logic [1:0] {LSC_FAILSAFE, LSC_NORMAL, LSC_SILENT, LSC_SLEEP} lsc_mode_t;
  typedef enum logic [1:0] {LSC_WD_LEAD, LSC_WD_CLOSED, LSC_WD_OPEN} lsc_wd_phase_t;

  function automatic logic [CW-1:0] lsc_inc(input logic [CW-1:0] c);
    lsc_inc = (c == {CW{1'b1}}) ? c : c + 24'h000001;
  endfunction

endpackage

// *** lsc_wd_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface lsc_wd_if;
  logic en;
  logic hold;
  logic kick_lvl;
  logic trig_ok;
  logic wd_rst;
  modport wd  (input en, input hold, input kick_lvl, output trig_ok, output wd_rst);
  modport ctl (output en, output hold, output kick_lvl, input trig_ok, input wd_rst);
endinterface
`default_nettype wire

// *** lsc_watchdog.sv ***
`timescale 1ns/1ps
`default_nettype none
module lsc_watchdog
  import lsc_pkg::*;
#(
  parameter logic [CW-1:0] LEAD_CYC   = CW'(WD_LEAD_CYC),
  parameter logic [CW-1:0] CLOSED_CYC = CW'(WD_CLOSED_CYC),
  parameter logic [CW-1:0] OPEN_CYC   = CW'(WD_OPEN_CYC)
)(
  input  wire logic clk,
  input  wire logic rst_b,
  lsc_wd_if.wd      wd
);

  typedef struct packed {
    lsc_wd_phase_t   phase;
    logic [CW-1:0]   cnt;
    logic [TW-1:0]   low_cnt;
    logic            trig_ok;
    logic            wd_rst;
  } lsc_wd_state_t;

  lsc_wd_state_t q;
  lsc_wd_state_t d;
  logic          trig;

  always_comb
  begin
    d = q;
    d.trig_ok = 1'h0;
    d.wd_rst = 1'h0;
    trig = 1'h0;
    // Width filter: a trigger counts only once the low phase is long enough
    if (!wd.kick_lvl)
    begin
      if (q.low_cnt < TW'(TRIG_MIN_CYC))
        d.low_cnt = q.low_cnt + 8'h01;
      trig = (q.low_cnt == TW'(TRIG_MIN_CYC - 1));
    end
    else
      d.low_cnt = '0;
    if (!wd.en || wd.hold)
    begin
      // Disabled or reset held: restart with the lead time
      d.phase = LSC_WD_LEAD;
      d.cnt = '0;
    end
    else
    begin
      d.cnt = lsc_inc(q.cnt);
      case (q.phase)
        LSC_WD_LEAD:
        begin
          if (trig)
          begin
            d.phase = LSC_WD_CLOSED;
            d.cnt = '0;
            d.trig_ok = 1'h1;
          end
          else if (q.cnt >= LEAD_CYC)
          begin
            d.wd_rst = 1'h1;
            d.cnt = '0;
          end
        end
        LSC_WD_CLOSED:
        begin
          if (trig)
          begin
            d.wd_rst = 1'h1;
            d.phase = LSC_WD_LEAD;
            d.cnt = '0;
          end
          else if (q.cnt >= CLOSED_CYC)
          begin
            d.phase = LSC_WD_OPEN;
            d.cnt = '0;
          end
        end
        LSC_WD_OPEN:
        begin
          if (trig)
          begin
            d.phase = LSC_WD_CLOSED;
            d.cnt = '0;
            d.trig_ok = 1'h1;
          end
          else if (q.cnt >= OPEN_CYC)
          begin
            d.wd_rst = 1'h1;
            d.phase = LSC_WD_LEAD;
            d.cnt = '0;
          end
        end
        default:
        begin
          d.phase = LSC_WD_LEAD;
          d.cnt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      q <= '0;
    else
      q <= d;
  end

  assign wd.trig_ok = q.trig_ok;
  assign wd.wd_rst  = q.wd_rst;

endmodule
`default_nettype wire

// *** lsc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module lsc_host_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       bus_dominant_out,
  input  wire logic       kick_go,
  input  wire logic [7:0] kick_len,
  output logic            bus_level_in,
  output logic            watchdog_kick_n
);
  logic [7:0] kick_cnt_q;
  // Bus pull-up wins unless our driver is on
  assign bus_level_in = !bus_dominant_out;
  // Pin rests high between kicks, pull-up
  assign watchdog_kick_n = (kick_cnt_q == 8'h00);
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      kick_cnt_q <= 8'h00;
    else if (kick_go)
      kick_cnt_q <= kick_len;
    else if (kick_cnt_q != 8'h00)
      kick_cnt_q <= kick_cnt_q - 8'h01;
  end
endmodule
`default_nettype wire

// *** lsc_chk_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module lsc_chk_monitor
  import lsc_pkg::*;
#(
  parameter logic [CW-1:0] RESET_HOLD = CW'(RESET_HOLD_CYC),
  parameter logic [CW-1:0] DOM_TO     = CW'(DOM_TO_CYC)
)(
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       txd_in,
  input wire logic       watchdog_disable_in,
  input wire logic       highside_ctrl_in,
  input wire logic       highside_fault_in,
  input wire logic       supply_uv_in,
  input wire logic       regulator_uv_in,
  input wire logic       bus_overtemp_in,
  input wire logic       rxd_out,
  input wire logic       bus_dominant_out,
  input wire logic       uv_reset_b,
  input wire logic       limp_home_out,
  input wire logic       highside_switch_out,
  input wire logic       watchdog_osc_ref,
  input wire logic [1:0] mode_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [15:0] dom_cnt_q;
  logic [15:0] ok_cnt_q;
  logic [15:0] uv_cnt_q;
  // Counters grow for well under 65536 cycles in this run, no saturation needed
  always_ff @(posedge clk)
  begin
    dom_cnt_q <= (!rst_b || !bus_dominant_out) ? 16'h0000 : dom_cnt_q + 16'h0001;
    ok_cnt_q  <= (!rst_b || regulator_uv_in) ? 16'h0000 : ok_cnt_q + 16'h0001;
    uv_cnt_q  <= (!rst_b || !regulator_uv_in) ? 16'h0000 : uv_cnt_q + 16'h0001;
  end
  sequence s_dis_held;
    watchdog_disable_in [*4];
  endsequence
  sequence s_enter_low;
    $past(mode_out) == 2'h1 ##0 mode_out inside {2'h2, 2'h3};
  endsequence
  AST_SILENT_RXD: assert property (mode_out == 2'h2 && $past(mode_out) == 2'h2 |-> rxd_out)
    else $error("receive output low in silent");
  AST_SLEEP_HS: assert property ($past(mode_out) == 2'h3 && mode_out == 2'h3
    |-> !highside_switch_out) else $error("switch on in sleep");
  AST_DOM_CAUSE: assert property (bus_dominant_out |-> (mode_out == 2'h1 ||
    $past(mode_out) == 2'h1) && !$past(txd_in, 3) && !$past(supply_uv_in, 3)
    && !$past(bus_overtemp_in, 3)) else $error("dominant without cause");
  AST_DOM_TIMEOUT: assert property (dom_cnt_q <= DOM_TO + 24'h000003)
    else $error("dominant too long");
  AST_HS_CAUSE: assert property (highside_switch_out |-> $past(highside_ctrl_in, 3)
    && !$past(highside_fault_in, 3)) else $error("switch on without control");
  AST_OSC_OFF: assert property (s_dis_held |=> !watchdog_osc_ref)
    else $error("oscillator reference on while disabled");
  AST_UV_FALL: assert property (uv_cnt_q > 16'h03F0 |-> !uv_reset_b)
    else $error("reset output high in undervoltage");
  AST_UV_HOLD: assert property ($rose(uv_reset_b) |-> ok_cnt_q >= RESET_HOLD)
    else $error("reset released early");
  AST_MODE_SEL: assert property (s_enter_low |-> (mode_out == 2'h3) == !$past(txd_in, 3))
    else $error("wrong low-power mode");
  AST_LH_FROZEN: assert property ($past(mode_out) == 2'h2 && mode_out == 2'h2
    |-> $stable(limp_home_out)) else $error("limp-home moved in silent");
  AST_LH_WD: assert property ($rose(limp_home_out) |-> ##[0:2] !uv_reset_b)
    else $error("limp-home on without reset");
endmodule
bind lsc_top lsc_chk_monitor #(.RESET_HOLD(RESET_HOLD), .DOM_TO(DOM_TO)) u_chk (.clk, .rst_b,
  .txd_in, .watchdog_disable_in, .highside_ctrl_in, .highside_fault_in, .supply_uv_in,
  .regulator_uv_in, .bus_overtemp_in, .rxd_out, .bus_dominant_out, .uv_reset_b,
  .limp_home_out, .highside_switch_out, .watchdog_osc_ref, .mode_out);
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import lsc_pkg::*;
  logic clk, rst_b, enable_in, txd_in, watchdog_kick_n, watchdog_disable_in;
  logic highside_ctrl_in, highside_fault_in, ignition_wake_in, local_wake_in;
  logic supply_uv_in, regulator_uv_in, bus_overtemp_in, bus_level_in, kick_go;
  logic txd_out, txd_oe_b, rxd_out, bus_dominant_out, uv_reset_b, limp_home_out;
  logic highside_switch_out, watchdog_osc_ref, regulator_on_out;
  logic [1:0] mode_out;
  logic [7:0] kick_len;
  int         failures;
  int         samples_checked;
  int         cycles;
  // Short counts keep the run brief; ignition debounce keeps its real length
  lsc_top #(.RESET_HOLD(24'h000032), .DOM_TO(24'h000064),
    .WD_LEAD(24'h00012C), .WD_CLOSED(24'h000064), .WD_OPEN(24'h000064)) dut (.clk, .rst_b,
    .enable_in, .txd_in, .txd_out, .txd_oe_b, .watchdog_kick_n, .watchdog_disable_in,
    .highside_ctrl_in, .highside_fault_in, .ignition_wake_in, .local_wake_in, .supply_uv_in,
    .regulator_uv_in, .bus_overtemp_in, .bus_level_in, .rxd_out, .bus_dominant_out,
    .uv_reset_b, .limp_home_out, .highside_switch_out, .watchdog_osc_ref, .regulator_on_out,
    .mode_out);
  lsc_host_model host (.clk, .rst_b, .bus_dominant_out, .kick_go, .kick_len, .bus_level_in,
    .watchdog_kick_n);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic check(input logic seen, input logic exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic kick(input logic [7:0] len, input int gap);
    kick_len <= len;
    kick_go <= 1'h1;
    cyc(1);
    kick_go <= 1'h0;
    cyc(gap);
  endtask
  task automatic tend(input string s);
    $display("end of test %s", s);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Hang guard, well above the expected run of about 25000 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      failures++;
      give_verdict();
    end
  end
  initial
  begin
    {rst_b, enable_in, highside_ctrl_in, highside_fault_in, ignition_wake_in} = 5'h00;
    {supply_uv_in, regulator_uv_in, bus_overtemp_in, kick_go} = 4'h0;
    {txd_in, watchdog_disable_in, local_wake_in} = 3'h7;
    kick_len = 8'h00;
    cyc(2);
    rst_b <= 1'h1;
    cyc(1);
    check(mode_out == 2'h0, 1'h1);
    check(regulator_on_out, 1'h1);
    check(txd_oe_b, 1'h0);
    check(txd_out, 1'h0);
    check(limp_home_out, 1'h0);
    cyc(45);
    check(uv_reset_b, 1'h0);
    cyc(15);
    check(uv_reset_b, 1'h1);
    check(watchdog_osc_ref, 1'h0);
    tend("power-up");
    enable_in <= 1'h1;
    cyc(1100);
    check(mode_out == 2'h1, 1'h1);
    check(txd_oe_b, 1'h1);
    txd_in <= 1'h0;
    cyc(8);
    check(bus_dominant_out, 1'h1);
    check(rxd_out, 1'h0);
    bus_overtemp_in <= 1'h1;
    cyc(5);
    check(bus_dominant_out, 1'h0);
    check(rxd_out, 1'h1);
    bus_overtemp_in <= 1'h0;
    supply_uv_in <= 1'h1;
    cyc(5);
    check(bus_dominant_out, 1'h0);
    supply_uv_in <= 1'h0;
    cyc(5);
    check(bus_dominant_out, 1'h1);
    cyc(100);
    check(bus_dominant_out, 1'h0);
    txd_in <= 1'h1;
    cyc(500);
    txd_in <= 1'h0;
    cyc(6);
    check(bus_dominant_out, 1'h0);
    txd_in <= 1'h1;
    cyc(1010);
    txd_in <= 1'h0;
    cyc(6);
    check(bus_dominant_out, 1'h1);
    txd_in <= 1'h1;
    highside_ctrl_in <= 1'h1;
    cyc(5);
    check(highside_switch_out, 1'h1);
    highside_fault_in <= 1'h1;
    cyc(5);
    check(highside_switch_out, 1'h0);
    highside_fault_in <= 1'h0;
    cyc(5);
    check(highside_switch_out, 1'h0);
    highside_ctrl_in <= 1'h0;
    cyc(5);
    highside_ctrl_in <= 1'h1;
    cyc(5);
    check(highside_switch_out, 1'h1);
    tend("transmit and switch");
    enable_in <= 1'h0;
    cyc(5);
    check(mode_out == 2'h2, 1'h1);
    check(rxd_out, 1'h1);
    check(highside_switch_out, 1'h1);
    ignition_wake_in <= 1'h1;
    cyc(9995);
    check(mode_out == 2'h2, 1'h1);
    cyc(20);
    check(mode_out == 2'h0, 1'h1);
    check(txd_out, 1'h1);
    txd_in <= 1'h0;
    cyc(5);
    enable_in <= 1'h1;
    cyc(8);
    check(mode_out == 2'h1, 1'h1);
    check(bus_dominant_out, 1'h0);
    cyc(110);
    enable_in <= 1'h0;
    cyc(5);
    check(mode_out == 2'h3, 1'h1);
    check(regulator_on_out, 1'h0);
    check(highside_switch_out, 1'h0);
    local_wake_in <= 1'h0;
    cyc(5);
    check(mode_out == 2'h0, 1'h1);
    check(limp_home_out, 1'h0);
    local_wake_in <= 1'h1;
    txd_in <= 1'h1;
    tend("modes and wake");
    watchdog_disable_in <= 1'h0;
    cyc(330);
    check(watchdog_osc_ref, 1'h1);
    check(limp_home_out, 1'h1);
    check(uv_reset_b, 1'h0);
    cyc(40);
    kick(8'h1E, 40);
    kick(8'h08, 109);
    kick(8'h1E, 149);
    check(limp_home_out, 1'h1);
    kick(8'h1E, 30);
    check(limp_home_out, 1'h0);
    check(uv_reset_b, 1'h1);
    kick(8'h1E, 30);
    check(uv_reset_b, 1'h0);
    check(limp_home_out, 1'h1);
    watchdog_disable_in <= 1'h1;
    cyc(60);
    tend("watchdog");
    regulator_uv_in <= 1'h1;
    cyc(990);
    check(uv_reset_b, 1'h1);
    cyc(20);
    check(uv_reset_b, 1'h0);
    regulator_uv_in <= 1'h0;
    cyc(45);
    check(uv_reset_b, 1'h0);
    cyc(15);
    check(uv_reset_b, 1'h1);
    tend("regulator");
    txd_in <= 1'h0;
    enable_in <= 1'h1;
    cyc(5);
    enable_in <= 1'h0;
    cyc(5);
    check(mode_out == 2'h3, 1'h1);
    check(limp_home_out, 1'h1);
    ignition_wake_in <= 1'h0;
    cyc(10020);
    check(mode_out == 2'h3, 1'h1);
    local_wake_in <= 1'h0;
    cyc(5);
    check(mode_out == 2'h0, 1'h1);
    check(limp_home_out, 1'h0);
    check(txd_out, 1'h1);
    rst_b <= 1'h0;
    local_wake_in <= 1'h1;
    cyc(2);
    rst_b <= 1'h1;
    cyc(1);
    check(txd_out, 1'h0);
    check(uv_reset_b, 1'h0);
    check(regulator_on_out, 1'h1);
    cyc(60);
    check(uv_reset_b, 1'h1);
    tend("sleep and reset");
    give_verdict();
  end
endmodule
`default_nettype wire
